// File: pkg/rcs_pkg.sv
// shared constants and types for the radio control serial interface
package rcs_pkg;
    localparam int unsigned CLK_MHZ  = 40;
    localparam int unsigned SER_BITS = 24;
    localparam int unsigned TYPE_BIT = 23;
    localparam int unsigned CRST_BIT = 22;
    localparam int unsigned WREN_BIT = 21;
    localparam int unsigned ADDR_HI  = 20;
    localparam int unsigned ADDR_LO  = 16;
    localparam int unsigned INT_HI   = 22;
    localparam int unsigned INT_LO   = 20;
    localparam int unsigned FRAC_HI  = 19;

    localparam logic [4:0]  CFG2_ADDR = 5'h02;
    localparam logic [4:0]  CFG3_ADDR = 5'h03;
    localparam logic [15:0] CFG2_RST  = 16'h4080;
    localparam logic [15:0] CFG3_RST  = 16'h8886;

    // configuration field positions
    localparam int unsigned ANA_BIT  = 13;
    localparam int unsigned SWD_HI   = 12;
    localparam int unsigned SWD_LO   = 8;
    localparam int unsigned CDR_BIT  = 7;
    localparam int unsigned RTD_HI   = 5;
    localparam int unsigned PAF_BIT  = 3;
    localparam int unsigned OFF_HI   = 2;
    localparam int unsigned OFF_LO   = 1;
    localparam int unsigned SKIP_BIT = 0;

    // switch and pa delays in reference periods
    localparam logic [10:0] RTD_OFS_SW = 11'd44;
    localparam logic [10:0] RTD_OFS_PA = 11'd47;
    localparam logic [10:0] PA_OFS     = 11'd6;
    localparam logic [10:0] DLY_STEP   = 11'd8;
    localparam logic [7:0]  OFF_OFS    = 8'd3;
    localparam logic [7:0]  OFF_STEP   = 8'd40;

    // settle times in microseconds and derived cycle counts
    localparam int unsigned RELOCK_FULL_US  = 115;
    localparam int unsigned RELOCK_SKIP_US  = 70;
    localparam int unsigned CAL_US          = 120;
    localparam int unsigned RELOCK_FULL_CYC = RELOCK_FULL_US * CLK_MHZ;
    localparam int unsigned RELOCK_SKIP_CYC = RELOCK_SKIP_US * CLK_MHZ;
    localparam int unsigned CAL_CYC         = CAL_US * CLK_MHZ;
    localparam int unsigned CNT_W           = 13;
    localparam logic [4:0]  RECOVERED_RX_CLOCK_HALF      = 5'h08;

    // apb register map
    localparam logic [7:0]  REG_CTRL   = 8'h00;
    localparam logic [7:0]  REG_STATUS = 8'h04;
    localparam logic [7:0]  REG_FREQ   = 8'h08;
    localparam logic [7:0]  REG_CFG2   = 8'h0C;
    localparam logic [7:0]  REG_CFG3   = 8'h10;
    localparam logic [31:0] CTRL_RST   = 32'h00000001;
    localparam int unsigned SWEN_BIT   = 0;
    localparam int unsigned CAL_BIT    = 1;

    typedef enum logic [1:0] {
        MODE_STBY = 2'b00,
        MODE_RX   = 2'b01,
        MODE_TX   = 2'b11
    } rcs_mode_e;
endpackage : rcs_pkg

// File: src/rcs_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none
module rcs_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         ref_clk,
    input  wire logic         sys_rst,
    input  wire logic [W-1:0] asyncIn,
    output var  logic [W-1:0] syncOut
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_reg <= '0;
            syncOut  <= '0;
        end else begin
            meta_reg <= asyncIn;
            syncOut  <= meta_reg;
        end
    end
endmodule : rcs_sync
`default_nettype wire

// File: src/rcs_serial_rx.sv
// three-wire serial word receiver working on synchronised pins
`timescale 1ns/100ps
`default_nettype none
module rcs_serial_rx import rcs_pkg::*; (
    input  wire logic                ref_clk,
    input  wire logic                sys_rst,
    input  wire logic                enSync,
    input  wire logic                clkSync,
    input  wire logic                dataSync,
    output var  logic [SER_BITS-1:0] wordOut,
    output var  logic                wordValid
);
    logic [SER_BITS-1:0] shift_reg;
    logic                clkPrev_reg;
    logic                enPrev_reg;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            clkPrev_reg <= 1'b0;
            enPrev_reg  <= 1'b1;
        end else begin
            clkPrev_reg <= clkSync;
            enPrev_reg  <= enSync;
        end
    end

    // msb arrives first, so shifting left leaves it at bit 23
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            shift_reg <= '0;
        end else if (!enSync && clkSync && !clkPrev_reg) begin
            shift_reg <= {shift_reg[SER_BITS-2:0], dataSync};
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wordOut   <= '0;
            wordValid <= 1'b0;
        end else begin
            wordValid <= enSync && !enPrev_reg;
            if (enSync && !enPrev_reg) begin
                wordOut <= shift_reg;
            end
        end
    end

    a_ser_ignore: assert property (
        @(posedge ref_clk) disable iff (sys_rst) enSync |=> $stable(shift_reg))
        else $error("shift register moved while enable high");
endmodule : rcs_serial_rx
`default_nettype wire

// File: src/rcs_top.sv
// control front end of the fsk transceiver: mode pins, serial words, switch timing
//
// Behaviour
// - chip-active low gives standby, high gives an active mode.
// - while active, receive-select picks receive or transmit.
// - standby ignores receive-select; 1/1 is receive, 1/0 is transmit.
// - positive switch high from its rise delay after select falls until its fall delay after select rises; negative is its complement.
// - both switch outputs held low while the pll is unlocked.
// - control pin transitions start a self-calibration before receive.
// - pa-before-switch 0 moves switch before pa; 1 moves it after.
// - switch rises 44 or 47 plus code times 8 periods after select falls.
// - pa and switch separated by 6 plus code times 8, or code times 8.
// - switch falls 3 plus code times 40 periods after select rises.
// - enable rise ending a frequency word restarts relock; data valid within 115/70.
// - configuration write during standby starts a full calibration.
// - transmit data passes straight through, never retimed.
// - analog-output bit selects the buffered filter output on the analog pin.
// - receive clock is recovered from slicer transitions.
// - reference clock times all control delays and calibration.
// - 24-bit words, msb first, 5-bit address and 16-bit data.
// - while enable low, data shifts on rising serial clock; else ignored.
// - enable rise moves the word into the addressed latch.
// - bit 23 zero marks a frequency word, one a configuration word.
// - frequency word holds integer part 22:20 and fraction 19:0.
// - configuration bit 22 resets, bit 21 enables write, 20:16 address.
//
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`default_nettype none
module rcs_top import rcs_pkg::*; #(
    parameter int unsigned RELOCK_CYC = RELOCK_FULL_CYC,
    parameter int unsigned CAL_LEN    = CAL_CYC
) (
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic        chipActivePin,
    input  wire logic        receiveSelectPin,
    input  wire logic        serEnPin,
    input  wire logic        serClkPin,
    input  wire logic        serDataPin,
    input  wire logic        pllLockPin,
    input  wire logic        slicerDataPin,
    input  wire logic        txDataPin,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    output var  logic        trSwitchPosOut,
    output var  logic        trSwitchNegOut,
    output var  logic        paEnableOut,
    output var  logic        calBusyOut,
    output var  logic        rxValidOut,
    output var  logic        analogFilterOut,
    output var  logic        recoveredRxClock,
    output wire logic        txModOut,
    output var  logic [2:0]  integerDividerPart,
    output var  logic [19:0] fractionalDividerPart
);
    logic [6:0]          pinSync;
    logic                actS, rxsS, lockS, slcS;
    logic [SER_BITS-1:0] serWord;
    logic                serValid;
    logic                freqLoad, cfgLoad;
    logic                actPrev_reg, rxsPrev_reg, slcPrev_reg;
    rcs_mode_e           mode_reg, mode_next;
    logic [15:0]         cfg2_reg, cfg3_reg;
    logic [31:0]         ctrl_reg;
    logic                calKick_reg;
    logic [CNT_W-1:0]    calCnt_reg, relockCnt_reg;
    logic [10:0]         txCnt_reg, swOnT, paOnT, swdDly;
    logic [7:0]          offCnt_reg, offT;
    logic                swPos_reg, swPos_next, paEn_next, calStart;
    logic                pa_before_switch, swEn;
    logic [4:0]          phase_reg;

    // enable crosses inverted: the sync resets low, which then reads as idle high
    rcs_sync #(.W(7)) u_sync (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .asyncIn ({chipActivePin, receiveSelectPin, ~serEnPin, serClkPin,
                   serDataPin, pllLockPin, slicerDataPin}),
        .syncOut (pinSync)
    );

    assign actS  = pinSync[6];
    assign rxsS  = pinSync[5];
    assign lockS = pinSync[1];
    assign slcS  = pinSync[0];

    rcs_serial_rx u_ser (
        .ref_clk   (ref_clk),
        .sys_rst   (sys_rst),
        .enSync    (~pinSync[4]),
        .clkSync   (pinSync[3]),
        .dataSync  (pinSync[2]),
        .wordOut   (serWord),
        .wordValid (serValid)
    );

    // chips go out untouched; any resampling would add jitter the modem cannot undo
    assign txModOut = txDataPin;

    assign freqLoad = serValid && !serWord[TYPE_BIT];
    assign cfgLoad  = serValid && serWord[TYPE_BIT] && serWord[WREN_BIT];
    assign pa_before_switch  = cfg3_reg[PAF_BIT];
    assign swEn     = ctrl_reg[SWEN_BIT];

    // ---- operating mode ----
    always_comb begin
        case ({actS, rxsS})
            2'b11:   mode_next = MODE_RX;
            2'b10:   mode_next = MODE_TX;
            default: mode_next = MODE_STBY;
        endcase
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mode_reg    <= MODE_STBY;
            actPrev_reg <= 1'b0;
            rxsPrev_reg <= 1'b0;
        end else begin
            mode_reg    <= mode_next;
            actPrev_reg <= actS;
            rxsPrev_reg <= rxsS;
        end
    end

    // ---- serial latches ----
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            integerDividerPart    <= '0;
            fractionalDividerPart <= '0;
        end else if (freqLoad) begin
            integerDividerPart    <= serWord[INT_HI:INT_LO];
            fractionalDividerPart <= serWord[FRAC_HI:0];
        end
    end

    // writes during an active mode are still taken; their effect is the controller's problem
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg2_reg <= CFG2_RST;
            cfg3_reg <= CFG3_RST;
        end else if (serValid && serWord[TYPE_BIT] && serWord[CRST_BIT]) begin
            cfg2_reg <= CFG2_RST;
            cfg3_reg <= CFG3_RST;
        end else if (cfgLoad) begin
            case (serWord[ADDR_HI:ADDR_LO])
                CFG2_ADDR: cfg2_reg <= serWord[15:0];
                CFG3_ADDR: cfg3_reg <= serWord[15:0];
                default:   cfg2_reg <= cfg2_reg;
            endcase
        end
    end

    // ---- calibration and relock ----
    assign calStart = (actS && !actPrev_reg) || (actS && rxsS && !rxsPrev_reg)
                      || (cfgLoad && !actS) || calKick_reg;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            calCnt_reg <= '0;
        end else if (calStart) begin
            calCnt_reg <= CNT_W'(CAL_LEN);
        end else if (calCnt_reg != '0) begin
            calCnt_reg <= calCnt_reg - 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            relockCnt_reg <= '0;
        end else if (freqLoad) begin
            relockCnt_reg <= cfg3_reg[SKIP_BIT] ? CNT_W'(RELOCK_SKIP_CYC) : CNT_W'(RELOCK_CYC);
        end else if (relockCnt_reg != '0) begin
            relockCnt_reg <= relockCnt_reg - 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            calBusyOut <= 1'b0;
            rxValidOut <= 1'b0;
        end else begin
            calBusyOut <= calCnt_reg != '0;
            rxValidOut <= mode_reg == MODE_RX && calCnt_reg == '0 && relockCnt_reg == '0 && lockS;
        end
    end

    // ---- switch and pa timing, counted in reference periods ----
    assign swdDly = 11'(cfg2_reg[SWD_HI:SWD_LO]) * DLY_STEP;
    assign swOnT  = (pa_before_switch ? RTD_OFS_PA : RTD_OFS_SW) + 11'(cfg2_reg[RTD_HI:0]) * DLY_STEP;
    assign offT   = OFF_OFS + 8'(cfg3_reg[OFF_HI:OFF_LO]) * OFF_STEP;

    always_comb begin
        if (!pa_before_switch) begin
            paOnT = swOnT + PA_OFS + swdDly;
        end else if (swOnT > swdDly) begin
            paOnT = swOnT - swdDly;
        end else begin
            paOnT = '0;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            txCnt_reg  <= '0;
            offCnt_reg <= '0;
        end else begin
            if (mode_reg != MODE_TX) begin
                txCnt_reg <= '0;
            end else if (txCnt_reg != '1) begin
                txCnt_reg <= txCnt_reg + 1'b1;
            end
            if (mode_reg != MODE_RX) begin
                offCnt_reg <= '0;
            end else if (offCnt_reg != '1) begin
                offCnt_reg <= offCnt_reg + 1'b1;
            end
        end
    end

    always_comb begin
        case (mode_reg)
            MODE_TX: swPos_next = swEn && (swPos_reg || txCnt_reg >= swOnT);
            MODE_RX: swPos_next = swEn && swPos_reg && offCnt_reg < offT;
            default: swPos_next = 1'b0;
        endcase
    end

    assign paEn_next = mode_reg == MODE_TX && txCnt_reg >= paOnT && lockS;

    // an unlocked synthesizer would key the switch onto a wandering carrier
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            swPos_reg      <= 1'b0;
            trSwitchPosOut <= 1'b0;
            trSwitchNegOut <= 1'b0;
            paEnableOut    <= 1'b0;
        end else begin
            swPos_reg      <= swPos_next;
            trSwitchPosOut <= lockS && swPos_next;
            trSwitchNegOut <= lockS && !swPos_next;
            paEnableOut    <= paEn_next;
        end
    end

    // ---- analog output select and receive clock recovery ----
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            analogFilterOut  <= 1'b0;
            slcPrev_reg      <= 1'b0;
            phase_reg        <= '0;
            recoveredRxClock <= 1'b0;
        end else begin
            analogFilterOut <= cfg2_reg[ANA_BIT];
            slcPrev_reg     <= slcS;
            if (slcS != slcPrev_reg || phase_reg == (RECOVERED_RX_CLOCK_HALF << 1) - 1'b1) begin
                phase_reg <= '0;
            end else begin
                phase_reg <= phase_reg + 1'b1;
            end
            recoveredRxClock <= cfg2_reg[CDR_BIT] && mode_reg == MODE_RX
                                && phase_reg >= RECOVERED_RX_CLOCK_HALF;
        end
    end

    // ---- apb slave: one wait-free access cycle after setup ----
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else if (psel && !penable) begin
            pready  <= 1'b1;
            pslverr <= !(paddr inside {REG_CTRL, REG_STATUS, REG_FREQ, REG_CFG2, REG_CFG3});
            case (paddr)
                REG_CTRL:   prdata <= ctrl_reg;
                REG_STATUS: prdata <= {25'h0, rxValidOut, calBusyOut, paEnableOut,
                                       swPos_reg, lockS, mode_reg};
                REG_FREQ:   prdata <= {9'h0, integerDividerPart, fractionalDividerPart};
                REG_CFG2:   prdata <= {16'h0, cfg2_reg};
                REG_CFG3:   prdata <= {16'h0, cfg3_reg};
                default:    prdata <= '0;
            endcase
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_reg    <= CTRL_RST;
            calKick_reg <= 1'b0;
        end else begin
            calKick_reg <= 1'b0;
            if (psel && penable && pready && pwrite && paddr == REG_CTRL) begin
                ctrl_reg    <= {31'h0, pwdata[SWEN_BIT]};
                calKick_reg <= pwdata[CAL_BIT];
            end
        end
    end

    // ---- checks ----
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    a_standby_rxstate: assert property (
        mode_reg == MODE_STBY |=> !trSwitchPosOut)
        else $error("switch left receive state in standby");

    a_switch_compl: assert property (
        lockS |=> trSwitchNegOut == !trSwitchPosOut)
        else $error("switch outputs not complementary");

    a_inhibit_lock: assert property (
        !lockS |=> !trSwitchPosOut && !trSwitchNegOut)
        else $error("switch driven while unlocked");

    a_pa_order: assert property (
        $rose(paEnableOut) && !pa_before_switch && swEn |-> trSwitchPosOut)
        else $error("pa enabled before switch");

    a_sw_rise_time: assert property (
        $rose(swPos_reg) && $past(swEn) |-> $past(txCnt_reg) == $past(swOnT))
        else $error("switch rise delay wrong");

    a_tx_off_time: assert property (
        $fell(swPos_reg) && $past(swEn) && $past(mode_reg) == MODE_RX
        |-> $past(offCnt_reg) == $past(offT))
        else $error("switch fall delay wrong");

    a_cfg_cal: assert property (
        cfgLoad && !actS |=> calCnt_reg != '0 ##1 calBusyOut)
        else $error("standby config write did not calibrate");

    a_relock_valid: assert property (
        freqLoad |-> ##2 !rxValidOut)
        else $error("receive data valid during relock");

    a_apb_ready: assert property (
        psel && !penable |=> pready ##1 !pready)
        else $error("apb ready not a single access cycle");

    c_tx_switch: cover property ($rose(trSwitchPosOut));
    c_freq_word: cover property (freqLoad);
    c_cfg_stby:  cover property (cfgLoad && !actS);
    c_apb_write: cover property (psel && penable && pready && pwrite);
endmodule : rcs_top
`default_nettype wire

// File: sim/rcs_ctrl_model.sv
// baseband controller model driving the mode pins and the three-wire serial bus
`timescale 1ns/100ps
`default_nettype none
module rcs_ctrl_model (
    input  wire logic ref_clk,
    output var  logic chipActivePin,
    output var  logic receiveSelectPin,
    output var  logic serEnPin,
    output var  logic serClkPin,
    output var  logic serDataPin
);
    initial begin
        chipActivePin    = 1'b0;
        receiveSelectPin = 1'b1;
        serEnPin         = 1'b1;
        serClkPin        = 1'b0;
        serDataPin       = 1'b0;
    end

    // pins move just after a reference edge, as a clocked controller would
    task automatic set_mode(input logic ce, input logic rs);
        @(posedge ref_clk);
        chipActivePin    <= ce;
        receiveSelectPin <= rs;
    endtask : set_mode

    // serial clock only runs inside a frame, 200 ns period, phase unrelated to ref_clk
    task automatic send_word(input logic [23:0] w);
        #37;
        serEnPin = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            serDataPin = w[i];
            #100;
            serClkPin = 1'b1;
            #100;
            serClkPin = 1'b0;
        end
        #50;
        serEnPin = 1'b1;
        // data flips after the frame so a stale bit never looks valid
        serDataPin = ~serDataPin;
        #300;
    endtask : send_word
endmodule : rcs_ctrl_model
`default_nettype wire

// File: sim/rcs_top_bench.sv
// self-checking bench for the radio control serial interface
`timescale 1ns/100ps
`default_nettype none
module rcs_top_bench import rcs_pkg::*; ;
    localparam int RELOCK = 200;
    localparam int CALN   = 100;
    logic        ref_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        pllLockPin = 1'b0;
    logic        slicerDataPin = 1'b0;
    logic        txDataPin = 1'b0;
    logic        slcRun = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        chipActivePin, receiveSelectPin, serEnPin, serClkPin, serDataPin;
    logic [31:0] prdata;
    logic        pready, pslverr, trSwitchPosOut, trSwitchNegOut, paEnableOut;
    logic        calBusyOut, rxValidOut, analogFilterOut, recoveredRxClock, txModOut;
    logic [2:0]  integerDividerPart;
    logic [19:0] fractionalDividerPart;
    logic [31:0] rnd = 32'h05F3;
    logic [31:0] q;
    logic        e;
    logic [15:0] cfg2M = CFG2_RST;
    logic [15:0] cfg3M = CFG3_RST;
    logic [22:0] freqM = 23'h0;
    logic [5:0]  rtd;
    logic [4:0]  swd;
    logic [1:0]  off;
    int          miscompares = 0;
    int          nTests = 0;
    int          cyc = 0;
    int          n, d;

    rcs_top #(.RELOCK_CYC(RELOCK), .CAL_LEN(CALN)) rcs_top_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .chipActivePin(chipActivePin), .receiveSelectPin(receiveSelectPin), .serEnPin(serEnPin),
        .serClkPin(serClkPin), .serDataPin(serDataPin), .pllLockPin(pllLockPin),
        .slicerDataPin(slicerDataPin), .txDataPin(txDataPin), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .trSwitchPosOut(trSwitchPosOut), .trSwitchNegOut(trSwitchNegOut),
        .paEnableOut(paEnableOut), .calBusyOut(calBusyOut), .rxValidOut(rxValidOut),
        .analogFilterOut(analogFilterOut), .recoveredRxClock(recoveredRxClock), .txModOut(txModOut),
        .integerDividerPart(integerDividerPart), .fractionalDividerPart(fractionalDividerPart));

    rcs_ctrl_model rcs_ctrl_model_i (.ref_clk(ref_clk), .chipActivePin(chipActivePin),
        .receiveSelectPin(receiveSelectPin), .serEnPin(serEnPin), .serClkPin(serClkPin),
        .serDataPin(serDataPin));

    initial forever #12.5 ref_clk = ~ref_clk;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    function automatic logic sig(input int k);
        return k == 0 ? trSwitchPosOut : k == 1 ? paEnableOut : k == 2 ? calBusyOut :
               k == 3 ? rxValidOut : recoveredRxClock;
    endfunction : sig

    task automatic summarize();
        if (miscompares == 0 && nTests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : summarize

    // a hang anywhere ends the run through the same report
    always @(posedge ref_clk) begin
        cyc++;
        rnd <= lfsr(rnd);
        slicerDataPin <= rnd[3] && slcRun;
        txDataPin <= rnd[7];
        if (cyc == 20000) begin
            miscompares++;
            summarize();
        end
    end

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        nTests++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] dat);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= dat;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) begin
            @(posedge ref_clk);
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask : apb

    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] x, input logic xe);
        apb(1'b0, a, 32'h0);
        check(nm, q, x);
        check(nm, 32'(e), 32'(xe));
    endtask : rdc

    task automatic stat(input string nm, input rcs_mode_e m);
        apb(1'b0, REG_STATUS, 32'h0);
        check(nm, 32'(q[1:0]), 32'(m));
    endtask : stat

    // reference model of the latches, updated from the rules for every word sent
    task automatic sendW(input logic [23:0] w);
        rcs_ctrl_model_i.send_word(w);
        if (!w[TYPE_BIT])
            freqM = w[22:0];
        else begin
            if (w[CRST_BIT]) begin
                cfg2M = CFG2_RST;
                cfg3M = CFG3_RST;
            end
            if (w[WREN_BIT] && w[20:16] == CFG2_ADDR)
                cfg2M = w[15:0];
            if (w[WREN_BIT] && w[20:16] == CFG3_ADDR)
                cfg3M = w[15:0];
        end
        repeat (8) @(posedge ref_clk);
    endtask : sendW

    task automatic waitFor(input int k, input logic v, output int c);
        c = 0;
        while (sig(k) !== v) begin
            @(posedge ref_clk);
            c++;
        end
    endtask : waitFor

    initial begin
        repeat (16) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        rdc("ctrl", REG_CTRL, CTRL_RST, 1'b0);
        rdc("cfg2", REG_CFG2, 32'(CFG2_RST), 1'b0);
        rdc("cfg3", REG_CFG3, 32'(CFG3_RST), 1'b0);
        rdc("unmapped", 8'h14, 32'h0, 1'b1);
        apb(1'b1, REG_FREQ, 32'h00FFFFFF);
        rdc("freq ro", REG_FREQ, 32'h0, 1'b0);
        apb(1'b1, REG_CTRL, 32'h3);
        rdc("ctrl wr", REG_CTRL, 32'h1, 1'b0);
        check("cal kick", 32'(calBusyOut), 32'h1);
        rtd = rnd[5:0];
        swd = rnd[12:8];
        off = rnd[17:16];
        rcs_ctrl_model_i.set_mode(1'b0, 1'b1);
        sendW({3'b101, CFG2_ADDR, 2'b01, 1'b1, swd, 2'b11, rtd});
        check("cal start", 32'(calBusyOut), 32'h1);
        check("analog", 32'(analogFilterOut), 32'h1);
        rdc("cfg2 wr", REG_CFG2, 32'(cfg2M), 1'b0);
        sendW({3'b101, CFG3_ADDR, 13'h1110, off, 1'b0});
        rdc("cfg3 wr", REG_CFG3, 32'(cfg3M), 1'b0);
        sendW({3'b100, CFG2_ADDR, 16'h0000});
        rdc("cfg2 keep", REG_CFG2, 32'(cfg2M), 1'b0);
        sendW({1'b0, rnd[22:0]});
        check("int part", 32'(integerDividerPart), 32'(freqM[22:20]));
        check("frac part", 32'(fractionalDividerPart), 32'(freqM[19:0]));
        rdc("freq", REG_FREQ, 32'(freqM), 1'b0);
        waitFor(2, 1'b0, n);
        pllLockPin <= 1'b1;
        rcs_ctrl_model_i.set_mode(1'b1, 1'b1);
        repeat (6) @(posedge ref_clk);
        check("wake cal", 32'(calBusyOut), 32'h1);
        waitFor(2, 1'b0, n);
        stat("mode rx", MODE_RX);
        rcs_ctrl_model_i.set_mode(1'b1, 1'b0);
        waitFor(0, 1'b1, n);
        d = n - 44 - 8 * rtd;
        check("sw on", 32'(d >= 0 && d <= 5), 32'h1);
        check("sw neg tx", 32'(trSwitchNegOut), 32'h0);
        waitFor(1, 1'b1, d);
        check("pa on", 32'(d >= 5 + 8 * swd && d <= 7 + 8 * swd), 32'h1);
        stat("mode tx", MODE_TX);
        pllLockPin <= 1'b0;
        repeat (6) @(posedge ref_clk);
        check("unlock pos", 32'(trSwitchPosOut), 32'h0);
        check("unlock neg", 32'(trSwitchNegOut), 32'h0);
        pllLockPin <= 1'b1;
        repeat (6) @(posedge ref_clk);
        check("relock pos", 32'(trSwitchPosOut), 32'h1);
        rcs_ctrl_model_i.set_mode(1'b1, 1'b1);
        waitFor(0, 1'b0, n);
        d = n - 3 - 40 * off;
        check("sw off", 32'(d >= 0 && d <= 5), 32'h1);
        check("sw neg rx", 32'(trSwitchNegOut), 32'h1);
        slcRun <= 1'b0;
        waitFor(4, 1'b1, n);
        check("recovered_rx_clock on", 32'(n <= 2 * RECOVERED_RX_CLOCK_HALF), 32'h1);
        waitFor(4, 1'b0, d);
        check("recovered_rx_clock half", d, 32'(RECOVERED_RX_CLOCK_HALF));
        waitFor(3, 1'b1, n);
        sendW({1'b0, rnd[30:8]});
        check("relock busy", 32'(rxValidOut), 32'h0);
        waitFor(3, 1'b1, n);
        check("relock time", 32'(n < RELOCK), 32'h1);
        rcs_ctrl_model_i.set_mode(1'b0, 1'b0);
        repeat (6) @(posedge ref_clk);
        check("stby pos", 32'(trSwitchPosOut), 32'h0);
        check("stby neg", 32'(trSwitchNegOut), 32'h1);
        check("stby recovered_rx_clock", 32'(recoveredRxClock), 32'h0);
        stat("mode stby", MODE_STBY);
        repeat (8) begin
            @(negedge ref_clk);
            check("tx pass", 32'(txModOut), 32'(txDataPin));
        end
        summarize();
    end
endmodule : rcs_top_bench
`default_nettype wire
